// ===== rtl/pwtq_core.sv
// pwtq_core: trigger qualifier for short-pulse, width, runt, window, timeout
// assumes: comparator bits synchronous to i_sys_clk, upper level above lower
`timescale 1ns/1ns

module pwtq_core
(
   input wire logic i_sys_clk, // sample clock
   input wire logic i_rst_b, // async reset, active low
   input wire pwtq_pkg::pwtq_cmp_s i_cmp, // comparator outputs
   input wire logic [3:0] i_addr, // register address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data, cycle after read strobe
   output logic o_trig // one-cycle trigger strobe
);

   localparam int unsigned W = pwtq_pkg::CNT_W;

   // configuration registers, read data and trigger count
   logic [31:0] ctrl_q, ctrl_d;
   logic [W-1:0] width_q, width_d;
   logic [W-1:0] delta_q, delta_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] ntrig_q, ntrig_d;

   // measurement state
   logic [W-1:0] cnt_q, cnt_d;
   logic meas_q, meas_d; // a qualifying start has been seen
   logic startpos_q, startpos_d; // pulse/runt started positive
   pwtq_pkg::pwtq_cmp_s prev_q, prev_d;
   logic trig_q, trig_d;

   // decoded fields
   logic en;
   pwtq_pkg::pwtq_mode_e mode;
   pwtq_pkg::pwtq_pol_e pol;
   pwtq_pkg::pwtq_rng_e rng;
   pwtq_pkg::pwtq_vcond_e vcond;
   pwtq_pkg::pwtq_torng_e torng;

   assign en = ctrl_q[pwtq_pkg::CTRL_EN_BIT];
   assign mode = pwtq_pkg::pwtq_mode_e'(ctrl_q[pwtq_pkg::CTRL_MODE_LSB +: 3]);
   assign pol = pwtq_pkg::pwtq_pol_e'(ctrl_q[pwtq_pkg::CTRL_POL_LSB +: 2]);
   assign rng = pwtq_pkg::pwtq_rng_e'(ctrl_q[pwtq_pkg::CTRL_RNG_LSB +: 3]);
   assign vcond =
      pwtq_pkg::pwtq_vcond_e'(ctrl_q[pwtq_pkg::CTRL_VCOND_LSB +: 2]);
   assign torng =
      pwtq_pkg::pwtq_torng_e'(ctrl_q[pwtq_pkg::CTRL_TORNG_LSB +: 2]);

   // band limits, saturated so low end never wraps
   logic [W:0] hi_lim;
   logic [W-1:0] lo_lim;
   assign hi_lim = {1'b0, width_q} + {1'b0, delta_q};
   assign lo_lim = (delta_q > width_q) ? '0 : width_q - delta_q;

   // duration compare against range setting
   function automatic logic dur_ok(input logic [W-1:0] d,
                                   input pwtq_pkg::pwtq_rng_e r);
      logic inb;
      inb = (d >= lo_lim) && ({1'b0, d} <= hi_lim);
      unique case (r)
         pwtq_pkg::PWTQ_R_LONGER: dur_ok = d > width_q;
         pwtq_pkg::PWTQ_R_SHORTER: dur_ok = d < width_q;
         pwtq_pkg::PWTQ_R_WITHIN: dur_ok = inb;
         pwtq_pkg::PWTQ_R_OUTSIDE: dur_ok = !inb;
         pwtq_pkg::PWTQ_R_ANY: dur_ok = 1'b1;
         default: dur_ok = 1'b0;
      endcase
   endfunction

   // crossing detection on each comparator
   logic rise_l, fall_l, rise_u, fall_u, rise_w, fall_w;
   logic in_band, was_band;
   assign rise_l = i_cmp.above_lvl && !prev_q.above_lvl;
   assign fall_l = !i_cmp.above_lvl && prev_q.above_lvl;
   assign rise_u = i_cmp.above_upr && !prev_q.above_upr;
   assign fall_u = !i_cmp.above_upr && prev_q.above_upr;
   assign rise_w = i_cmp.above_lwr && !prev_q.above_lwr;
   assign fall_w = !i_cmp.above_lwr && prev_q.above_lwr;
   assign in_band = i_cmp.above_lwr && !i_cmp.above_upr;
   assign was_band = prev_q.above_lwr && !prev_q.above_upr;

   logic pos_ok, neg_ok;
   assign pos_ok = (pol != pwtq_pkg::PWTQ_P_NEG);
   assign neg_ok = (pol != pwtq_pkg::PWTQ_P_POS);

   logic [W-1:0] cnt_inc;
   assign cnt_inc = (cnt_q == pwtq_pkg::CNT_MAX) ? cnt_q : cnt_q + 1'b1;

   // measurement and trigger qualification
   always_comb
   begin
      cnt_d = cnt_inc;
      meas_d = meas_q;
      startpos_d = startpos_q;
      prev_d = i_cmp;
      trig_d = 1'b0;
      if (!en)
      begin
         meas_d = 1'b0;
         cnt_d = '0;
      end
      else
      begin
         unique case (mode)
            pwtq_pkg::PWTQ_M_SHORT,
            pwtq_pkg::PWTQ_M_WIDTH:
            begin
               // start on the opening edge, stop on the closing edge
               if (meas_q && ((startpos_q && fall_l) ||
                              (!startpos_q && rise_l)))
               begin
                  trig_d = dur_ok(cnt_q, rng);
                  meas_d = 1'b0;
               end
               if ((rise_l && pos_ok) || (fall_l && neg_ok))
               begin
                  meas_d = 1'b1;
                  startpos_d = rise_l;
                  cnt_d = '0;
               end
            end
            pwtq_pkg::PWTQ_M_RUNT:
            begin
               // positive runt leaves above lower, drops back below it
               if (meas_q && startpos_q && rise_u)
                  meas_d = 1'b0;
               else if (meas_q && !startpos_q && fall_w)
                  meas_d = 1'b0;
               else if (meas_q && startpos_q && fall_w)
               begin
                  trig_d = dur_ok(cnt_q, rng);
                  meas_d = 1'b0;
               end
               else if (meas_q && !startpos_q && rise_u)
               begin
                  trig_d = dur_ok(cnt_q, rng);
                  meas_d = 1'b0;
               end
               // a sample that jumps both levels is a full edge, not a runt
               if (!meas_d &&
                   ((rise_w && !i_cmp.above_upr && pos_ok) ||
                    (fall_u && i_cmp.above_lwr && neg_ok)))
               begin
                  meas_d = 1'b1;
                  startpos_d = rise_w;
                  cnt_d = '0;
               end
            end
            pwtq_pkg::PWTQ_M_WINDOW:
            begin
               meas_d = 1'b1;
               unique case (vcond)
                  pwtq_pkg::PWTQ_V_ENTER: trig_d = in_band && !was_band;
                  pwtq_pkg::PWTQ_V_EXIT: trig_d = !in_band && was_band;
                  default:
                  begin
                     // time the stay, judge at the exit crossing
                     if (in_band != was_band)
                     begin
                        cnt_d = '0;
                        if (meas_q && ((vcond == pwtq_pkg::PWTQ_V_STAY_IN)
                                       == was_band))
                           trig_d = dur_ok(cnt_q, rng);
                     end
                  end
               endcase
            end
            pwtq_pkg::PWTQ_M_TIMEOUT:
            begin
               meas_d = 1'b1;
               // startpos marks a stay that already fired, so a count held
               // at its ceiling cannot strobe again
               if (rise_l || fall_l || !meas_q)
               begin
                  cnt_d = '0;
                  startpos_d = 1'b0;
               end
               else if (!startpos_q && cnt_q == width_q &&
                        ((torng == pwtq_pkg::PWTQ_T_EITHER) ||
                         ((torng == pwtq_pkg::PWTQ_T_HIGH) ==
                          i_cmp.above_lvl)))
               begin
                  trig_d = 1'b1;
                  startpos_d = 1'b1;
               end
            end
            default:
               meas_d = 1'b0;
         endcase
      end
   end

   // register port: writes and read data one cycle later
   always_comb
   begin
      ctrl_d = ctrl_q;
      width_d = width_q;
      delta_d = delta_q;
      ntrig_d = trig_q ? ntrig_q + 16'h0001 : ntrig_q;
      rdata_d = 32'h00000000;
      if (i_wr)
      begin
         unique case (i_addr)
            pwtq_pkg::ADR_CTRL: ctrl_d = i_wdata;
            pwtq_pkg::ADR_WIDTH: width_d = i_wdata[W-1:0];
            pwtq_pkg::ADR_DELTA: delta_d = i_wdata[W-1:0];
            pwtq_pkg::ADR_COUNT: ntrig_d = 16'h0000;
            default: ;
         endcase
      end
      if (i_rd)
      begin
         unique case (i_addr)
            pwtq_pkg::ADR_CTRL: rdata_d = ctrl_q;
            pwtq_pkg::ADR_WIDTH: rdata_d = {8'h00, width_q};
            pwtq_pkg::ADR_DELTA: rdata_d = {8'h00, delta_q};
            pwtq_pkg::ADR_STATUS: rdata_d = {8'h00, cnt_q[W-1:1], meas_q};
            pwtq_pkg::ADR_COUNT: rdata_d = {16'h0000, ntrig_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // state registers
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_q <= pwtq_pkg::CTRL_RST;
         width_q <= pwtq_pkg::WIDTH_RST;
         delta_q <= pwtq_pkg::DELTA_RST;
         rdata_q <= 32'h00000000;
         ntrig_q <= 16'h0000;
         cnt_q <= '0;
         meas_q <= 1'b0;
         startpos_q <= 1'b0;
         prev_q <= '0;
         trig_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         width_q <= width_d;
         delta_q <= delta_d;
         rdata_q <= rdata_d;
         ntrig_q <= ntrig_d;
         cnt_q <= cnt_d;
         meas_q <= meas_d;
         startpos_q <= startpos_d;
         prev_q <= prev_d;
         trig_q <= trig_d;
      end
   end

   assign o_trig = trig_q;
   assign o_rdata = rdata_q;

   // checks
   property p_trig_one;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_TIMEOUT && trig_d && !i_wr) |=>
      !trig_d;
   endproperty
   a_trig_one: assert property (p_trig_one)
      else $error("timeout strobe repeated within one stay");

   property p_width_exact;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WIDTH && rng == pwtq_pkg::PWTQ_R_WITHIN
       && delta_q == '0 && trig_d) |-> cnt_q == width_q;
   endproperty
   a_width_exact: assert property (p_width_exact)
      else $error("exact width trigger on wrong duration");

   property p_width_ne;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WIDTH && rng == pwtq_pkg::PWTQ_R_OUTSIDE
       && delta_q == '0 && trig_d) |-> cnt_q != width_q;
   endproperty
   a_width_ne: assert property (p_width_ne)
      else $error("outside width trigger on equal duration");

   property p_longer;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WIDTH && rng == pwtq_pkg::PWTQ_R_LONGER
       && trig_d) |-> cnt_q > width_q;
   endproperty
   a_longer: assert property (p_longer)
      else $error("longer trigger on short pulse");

   property p_enter;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WINDOW &&
       vcond == pwtq_pkg::PWTQ_V_ENTER && in_band && !was_band) |=> o_trig;
   endproperty
   a_enter: assert property (p_enter)
      else $error("window enter missed");

   property p_timeout;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_TIMEOUT && trig_d) |->
      !rise_l && !fall_l && cnt_q == width_q;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout fired off its limit");

   property p_pol;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WIDTH && pol == pwtq_pkg::PWTQ_P_POS
       && trig_d) |-> fall_l;
   endproperty
   a_pol: assert property (p_pol)
      else $error("positive pulse closed on wrong edge");

   property p_restart;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WIDTH && rise_l && pos_ok) |=>
      cnt_q == '0 && meas_q;
   endproperty
   a_restart: assert property (p_restart)
      else $error("measurement did not restart at crossing");

   property p_runt_close;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_RUNT && trig_d && startpos_q) |->
      fall_w && !rise_u;
   endproperty
   a_runt_close: assert property (p_runt_close)
      else $error("positive runt closed off the lower level");

   property p_off;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      !en |=> !o_trig;
   endproperty
   a_off: assert property (p_off)
      else $error("trigger while disabled");

   property p_to_side;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_TIMEOUT &&
       torng == pwtq_pkg::PWTQ_T_LOW && trig_d) |-> !i_cmp.above_lvl;
   endproperty
   a_to_side: assert property (p_to_side)
      else $error("low timeout fired while high");

   property p_exit;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WINDOW &&
       vcond == pwtq_pkg::PWTQ_V_EXIT && !in_band && was_band) |=> o_trig;
   endproperty
   a_exit: assert property (p_exit)
      else $error("window exit missed");

   property p_edge_only;
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (en && mode == pwtq_pkg::PWTQ_M_WINDOW && trig_d &&
       (vcond == pwtq_pkg::PWTQ_V_ENTER || vcond == pwtq_pkg::PWTQ_V_EXIT))
      |-> in_band != was_band;
   endproperty
   a_edge_only: assert property (p_edge_only)
      else $error("enter or exit fired without a crossing");

endmodule // pwtq_core

// ===== common/pwtq_pkg.sv
// pwtq_pkg: constants and types for the pulse/window/timeout trigger qualifier
// assumes: a single sample clock; comparator inputs synchronous to it
package pwtq_pkg;

   // duration counters and width/tolerance settings
   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;

   // register map (word offsets on the plain register port)
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_WIDTH = 4'h1;
   localparam logic [3:0] ADR_DELTA = 4'h2;
   localparam logic [3:0] ADR_STATUS = 4'h3;
   localparam logic [3:0] ADR_COUNT = 4'h4;

   // control register field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_POL_LSB = 4;
   localparam int unsigned CTRL_RNG_LSB = 8;
   localparam int unsigned CTRL_VCOND_LSB = 12;
   localparam int unsigned CTRL_TORNG_LSB = 16;
   localparam int unsigned CTRL_EN_BIT = 31;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [CNT_W-1:0] WIDTH_RST = 24'h000010;
   localparam logic [CNT_W-1:0] DELTA_RST = 24'h000000;

   typedef enum logic [2:0] {
      PWTQ_M_SHORT, PWTQ_M_WIDTH, PWTQ_M_RUNT, PWTQ_M_WINDOW, PWTQ_M_TIMEOUT
   } pwtq_mode_e;

   typedef enum logic [1:0] {
      PWTQ_P_POS, PWTQ_P_NEG, PWTQ_P_EITHER
   } pwtq_pol_e;

   // range: shared by short-pulse, width, runt and window time condition
   typedef enum logic [2:0] {
      PWTQ_R_LONGER, PWTQ_R_SHORTER, PWTQ_R_WITHIN, PWTQ_R_OUTSIDE, PWTQ_R_ANY
   } pwtq_rng_e;

   typedef enum logic [1:0] {
      PWTQ_V_ENTER, PWTQ_V_EXIT, PWTQ_V_STAY_IN, PWTQ_V_STAY_OUT
   } pwtq_vcond_e;

   typedef enum logic [1:0] {
      PWTQ_T_LOW, PWTQ_T_HIGH, PWTQ_T_EITHER
   } pwtq_torng_e;

   // comparator outputs: single level and upper/lower levels
   typedef struct packed {
      logic above_lvl;
      logic above_upr;
      logic above_lwr;
   } pwtq_cmp_s;

endpackage

// ===== tb/pwtq_cmp_model.sv
// pwtq_cmp_model: comparators watching the trigger source
// assumes: the source level arrives as a code, lower < level < upper
`timescale 1ns/1ns
module pwtq_cmp_model
(
   input wire logic [1:0] i_lvl, // 0 below lower .. 3 above upper
   output pwtq_pkg::pwtq_cmp_s o_cmp // comparator outputs
);
   // thresholds are ordered, so the three flags stay consistent
   assign o_cmp.above_lwr = (i_lvl >= 2'h1);
   assign o_cmp.above_lvl = (i_lvl >= 2'h2);
   assign o_cmp.above_upr = (i_lvl == 2'h3);
endmodule // pwtq_cmp_model

// ===== tb/pwtq_core_tb.sv
// pwtq_core_tb: self-checking bench for the trigger qualifier
// assumes: comparator model on i_cmp, register port with one-cycle reads
`timescale 1ns/1ns
module pwtq_core_tb;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h00000000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [1:0] lvl = 2'h1;
   logic [31:0] o_rdata;
   logic o_trig;
   pwtq_pkg::pwtq_cmp_s cmp;
   int failures = 0;
   int total_checks = 0;
   int ntrig = 0;
   int cyc = 0;

   pwtq_cmp_model u_cmp (.i_lvl(lvl), .o_cmp(cmp));
   pwtq_core u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cmp(cmp),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_trig(o_trig));

   // 250 MHz sample clock
   initial
   begin
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   // trigger strobe cycles and the hang guard
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (o_trig === 1'b1)
         ntrig <= ntrig + 1;
      if (i_rst_b === 1'b1 && o_trig !== 1'b0 && o_trig !== 1'b1)
      begin
         failures++;
         $display("BAD %0t trigger unknown", $time);
      end
      if (cyc == 20000)
      begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // control word, always enabled
   function automatic logic [31:0] cw(input int m, p, r, v, t);
      cw = 32'h80000000 | (m << pwtq_pkg::CTRL_MODE_LSB)
         | (p << pwtq_pkg::CTRL_POL_LSB) | (r << pwtq_pkg::CTRL_RNG_LSB)
         | (v << pwtq_pkg::CTRL_VCOND_LSB) | (t << pwtq_pkg::CTRL_TORNG_LSB);
   endfunction

   // settle base level disabled, configure, hold pulse h samples, count
   task automatic rc(input logic [31:0] c, input int w, dl, input int b,
      input int p, input int h, input int e);
      int n0;
      wr(pwtq_pkg::ADR_CTRL, 32'h00000000);
      lvl <= 2'(b);
      repeat (3) @(posedge i_sys_clk);
      wr(pwtq_pkg::ADR_WIDTH, 32'(w));
      wr(pwtq_pkg::ADR_DELTA, 32'(dl));
      wr(pwtq_pkg::ADR_CTRL, c);
      n0 = ntrig;
      @(posedge i_sys_clk);
      lvl <= 2'(p);
      repeat (h) @(posedge i_sys_clk);
      lvl <= 2'(b);
      repeat (4) @(posedge i_sys_clk);
      #1 chk((ntrig - n0) == e, "trigger count");
   endtask

   task automatic t_regs();
      logic [31:0] v;
      rd(pwtq_pkg::ADR_CTRL, v);
      chk(v === 32'h00000000, "ctrl reset");
      rd(pwtq_pkg::ADR_WIDTH, v);
      chk(v === 32'h00000010, "width reset");
      rd(pwtq_pkg::ADR_DELTA, v);
      chk(v === 32'h00000000, "delta reset");
      rd(pwtq_pkg::ADR_STATUS, v);
      chk(v === 32'h00000000, "status idle while disabled");
      wr(4'hF, 32'hFFFFFFFF);
      rd(4'hF, v);
      chk(v === 32'h00000000, "unmapped read");
      wr(pwtq_pkg::ADR_COUNT, 32'h00000000);
      rc(cw(1, 0, 0, 0, 0) & 32'h7FFFFFFF, 4, 0, 1, 2, 6, 0);
      rc(cw(1, 0, 0, 0, 0), 4, 0, 1, 2, 6, 1);
      rd(pwtq_pkg::ADR_COUNT, v);
      chk(v === 32'h00000001, "trigger count register");
      $display("test regs done");
   endtask

   task automatic t_width();
      rc(cw(1, 0, 0, 0, 0), 4, 0, 1, 2, 6, 1);
      rc(cw(1, 0, 0, 0, 0), 4, 0, 1, 2, 5, 0);
      rc(cw(1, 0, 1, 0, 0), 4, 0, 1, 2, 4, 1);
      rc(cw(1, 0, 1, 0, 0), 4, 0, 1, 2, 5, 0);
      rc(cw(1, 0, 2, 0, 0), 4, 0, 1, 2, 5, 1);
      rc(cw(1, 0, 2, 0, 0), 4, 0, 1, 2, 6, 0);
      rc(cw(1, 0, 3, 0, 0), 4, 0, 1, 2, 6, 1);
      rc(cw(1, 0, 3, 0, 0), 4, 0, 1, 2, 5, 0);
      rc(cw(1, 0, 2, 0, 0), 4, 1, 1, 2, 4, 1);
      rc(cw(1, 0, 3, 0, 0), 4, 1, 1, 2, 4, 0);
      rc(cw(1, 0, 3, 0, 0), 4, 1, 1, 2, 3, 1);
      $display("test width done");
   endtask

   task automatic t_pol();
      rc(cw(1, 1, 1, 0, 0), 4, 0, 2, 1, 2, 1);
      rc(cw(1, 0, 1, 0, 0), 4, 0, 2, 1, 2, 0);
      rc(cw(1, 2, 1, 0, 0), 4, 0, 2, 1, 2, 1);
      rc(cw(1, 2, 1, 0, 0), 4, 0, 1, 2, 2, 1);
      $display("test polarity done");
   endtask

   task automatic t_short();
      rc(cw(0, 0, 1, 0, 0), 4, 0, 1, 2, 3, 1);
      rc(cw(0, 0, 0, 0, 0), 4, 0, 1, 2, 3, 0);
      rc(cw(0, 0, 0, 0, 0), 4, 0, 1, 2, 7, 1);
      $display("test short done");
   endtask

   task automatic t_runt();
      rc(cw(2, 0, 4, 0, 0), 4, 0, 0, 1, 3, 1);
      rc(cw(2, 0, 4, 0, 0), 4, 0, 0, 3, 3, 0);
      rc(cw(2, 0, 0, 0, 0), 4, 0, 0, 1, 7, 1);
      rc(cw(2, 0, 1, 0, 0), 4, 0, 0, 1, 7, 0);
      rc(cw(2, 0, 2, 0, 0), 4, 0, 0, 1, 5, 1);
      rc(cw(2, 1, 4, 0, 0), 4, 0, 3, 1, 3, 1);
      rc(cw(2, 1, 4, 0, 0), 4, 0, 3, 0, 3, 0);
      $display("test runt done");
   endtask

   task automatic t_window();
      rc(cw(3, 0, 3, 0, 0), 4, 0, 0, 1, 5, 1);
      rc(cw(3, 0, 0, 1, 0), 4, 0, 0, 1, 3, 1);
      rc(cw(3, 0, 2, 2, 0), 4, 1, 0, 1, 5, 1);
      rc(cw(3, 0, 2, 2, 0), 4, 1, 0, 1, 3, 0);
      rc(cw(3, 0, 3, 2, 0), 4, 1, 0, 1, 3, 1);
      rc(cw(3, 0, 3, 2, 0), 4, 1, 0, 1, 5, 0);
      rc(cw(3, 0, 1, 2, 0), 4, 0, 0, 1, 3, 1);
      rc(cw(3, 0, 0, 2, 0), 4, 0, 0, 1, 3, 0);
      rc(cw(3, 0, 0, 3, 0), 4, 0, 1, 3, 7, 1);
      rc(cw(3, 0, 1, 3, 0), 4, 0, 1, 3, 7, 0);
      $display("test window done");
   endtask

   task automatic t_timeout();
      rc(cw(4, 0, 0, 0, 0), 4, 0, 2, 1, 10, 1);
      rc(cw(4, 0, 0, 0, 0), 4, 0, 2, 1, 3, 0);
      rc(cw(4, 0, 0, 0, 1), 4, 0, 1, 2, 10, 1);
      rc(cw(4, 0, 0, 0, 0), 4, 0, 1, 2, 10, 0);
      rc(cw(4, 0, 0, 0, 2), 4, 0, 2, 1, 10, 1);
      $display("test timeout done");
   endtask

   // reset for three cycles, then the scenarios
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      #1 chk(o_trig === 1'b0, "trigger idle after reset");
      t_regs();
      t_width();
      t_pol();
      t_short();
      t_runt();
      t_window();
      t_timeout();
      stop_test();
   end
endmodule // pwtq_core_tb
